// >>> logic/trppc_pin_ctrl.sv
// Purpose: test reset and quadrature phase pin control with wishbone registers
// Assumes: classic wishbone slave on mclk, one cycle answer, all pins synchronous
// Notes: phase pins default to the decoder, all pull-ups on after device reset
`timescale 1ns/1ps
module trppc_pin_ctrl
  import trppc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [TRPPC_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [TRPPC_DW-1:0] wb_dat_i,
  output logic [TRPPC_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trst_n,
  output logic trst_pullup,
  output logic tap_ctrl_rst,
  input wire logic phase_a_pad_in,
  output logic phase_a_pad_out,
  output logic phase_a_pad_oe,
  output logic phase_a_pullup,
  input wire logic phase_b_pad_in,
  output logic phase_b_pad_out,
  output logic phase_b_pad_oe,
  output logic phase_b_pullup,
  output logic quad_phase_a_in,
  output logic quad_phase_b_in,
  input wire logic timer_a_ch0_pin_out,
  input wire logic timer_a_ch0_pin_oe,
  output logic timer_a_ch0_pin_in,
  input wire logic timer_a_ch1_pin_out,
  input wire logic timer_a_ch1_pin_oe,
  output logic timer_a_ch1_pin_in,
  output logic portc_line_4,
  output logic portc_line_5
);
  logic pur_a;
  logic pur_b;
  logic pud_test;
  trppc_fn_t sel_a;
  trppc_fn_t sel_b;
  logic dir_a;
  logic dir_b;
  logic dout_a;
  logic dout_b;

  logic next_pur_a;
  logic next_pur_b;
  logic next_pud_test;
  trppc_fn_t next_sel_a;
  trppc_fn_t next_sel_b;
  logic next_dir_a;
  logic next_dir_b;
  logic next_dout_a;
  logic next_dout_b;
  logic next_ack;
  logic [TRPPC_DW-1:0] next_dat;

  logic req;
  logic wr;
  logic [TRPPC_AW-1:0] word_adr;
  logic [7:0] wbyte;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // only byte lane 0 carries register bits, other lanes are ignored
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign word_adr = {wb_adr_i[TRPPC_AW-1:2], 2'b00};
  assign wbyte = wb_dat_i[7:0];

  // bus answer and read data
  always_comb begin
    next_ack = req;
    next_dat = '0;
    if (req && !wb_we_i) begin
      case (word_adr)
        TRPPC_OFS_PORTC_PUR: begin
          next_dat[TRPPC_LINE_A_BIT] = pur_a;
          next_dat[TRPPC_LINE_B_BIT] = pur_b;
        end
        TRPPC_OFS_SYS_PUD: begin
          next_dat[TRPPC_PUD_TEST_BIT] = pud_test;
        end
        TRPPC_OFS_FUNC_SEL: begin
          next_dat[TRPPC_SEL_A_LSB +: 2] = sel_a;
          next_dat[TRPPC_SEL_B_LSB +: 2] = sel_b;
        end
        TRPPC_OFS_PORTC_DIR: begin
          next_dat[TRPPC_LINE_A_BIT] = dir_a;
          next_dat[TRPPC_LINE_B_BIT] = dir_b;
        end
        TRPPC_OFS_PORTC_DATA: begin
          next_dat[TRPPC_LINE_A_BIT] = dout_a;
          next_dat[TRPPC_LINE_B_BIT] = dout_b;
        end
        TRPPC_OFS_STATUS: begin
          next_dat[TRPPC_ST_TRST_N_BIT] = trst_n;
          next_dat[TRPPC_ST_TAP_RST_BIT] = tap_ctrl_rst;
          next_dat[TRPPC_LINE_A_BIT] = phase_a_pad_in;
          next_dat[TRPPC_LINE_B_BIT] = phase_b_pad_in;
        end
        // unmapped words still answer, reading zero, so the bus never hangs
        default: begin
          next_dat = '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // configuration registers
  always_comb begin
    next_pur_a = pur_a;
    next_pur_b = pur_b;
    next_pud_test = pud_test;
    next_sel_a = sel_a;
    next_sel_b = sel_b;
    next_dir_a = dir_a;
    next_dir_b = dir_b;
    next_dout_a = dout_a;
    next_dout_b = dout_b;
    if (wr) begin
      case (word_adr)
        TRPPC_OFS_PORTC_PUR: begin
          next_pur_a = wbyte[TRPPC_LINE_A_BIT];
          next_pur_b = wbyte[TRPPC_LINE_B_BIT];
        end
        TRPPC_OFS_SYS_PUD: begin
          next_pud_test = wbyte[TRPPC_PUD_TEST_BIT];
        end
        TRPPC_OFS_FUNC_SEL: begin
          next_sel_a = trppc_fn_t'(wbyte[TRPPC_SEL_A_LSB +: 2]);
          next_sel_b = trppc_fn_t'(wbyte[TRPPC_SEL_B_LSB +: 2]);
        end
        TRPPC_OFS_PORTC_DIR: begin
          next_dir_a = wbyte[TRPPC_LINE_A_BIT];
          next_dir_b = wbyte[TRPPC_LINE_B_BIT];
        end
        TRPPC_OFS_PORTC_DATA: begin
          next_dout_a = wbyte[TRPPC_LINE_A_BIT];
          next_dout_b = wbyte[TRPPC_LINE_B_BIT];
        end
        default: begin
          next_pur_a = pur_a;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pur_a <= TRPPC_PUR_RST;
      pur_b <= TRPPC_PUR_RST;
      pud_test <= TRPPC_PUD_RST;
      sel_a <= TRPPC_SEL_RST;
      sel_b <= TRPPC_SEL_RST;
      dir_a <= TRPPC_DIR_RST;
      dir_b <= TRPPC_DIR_RST;
      dout_a <= TRPPC_DOUT_RST;
      dout_b <= TRPPC_DOUT_RST;
    end else begin
      pur_a <= next_pur_a;
      pur_b <= next_pur_b;
      pud_test <= next_pud_test;
      sel_a <= next_sel_a;
      sel_b <= next_sel_b;
      dir_a <= next_dir_a;
      dir_b <= next_dir_b;
      dout_a <= next_dout_a;
      dout_b <= next_dout_b;
    end
  end

  trppc_test_reset u_test_reset (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .trst_n(trst_n),
    .pud_test(pud_test),
    .tap_ctrl_rst(tap_ctrl_rst),
    .trst_pullup(trst_pullup)
  );

  trppc_phase_pin u_phase_a (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .fn(sel_a),
    .pullup_en(pur_a),
    .gpio_dir(dir_a),
    .gpio_dout(dout_a),
    .timer_out(timer_a_ch0_pin_out),
    .timer_oe(timer_a_ch0_pin_oe),
    .pad_in(phase_a_pad_in),
    .pad_out(phase_a_pad_out),
    .pad_oe(phase_a_pad_oe),
    .pad_pullup(phase_a_pullup),
    .decoder_in(quad_phase_a_in),
    .timer_in(timer_a_ch0_pin_in),
    .gpio_din(portc_line_4)
  );

  trppc_phase_pin u_phase_b (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .fn(sel_b),
    .pullup_en(pur_b),
    .gpio_dir(dir_b),
    .gpio_dout(dout_b),
    .timer_out(timer_a_ch1_pin_out),
    .timer_oe(timer_a_ch1_pin_oe),
    .pad_in(phase_b_pad_in),
    .pad_out(phase_b_pad_out),
    .pad_oe(phase_b_pad_oe),
    .pad_pullup(phase_b_pullup),
    .decoder_in(quad_phase_b_in),
    .timer_in(timer_a_ch1_pin_in),
    .gpio_din(portc_line_5)
  );

  property p_tap_ignores_sys_rst;
    @(posedge mclk) (sys_rst && trst_n) |=> !tap_ctrl_rst;
  endproperty
  a_tap_ignores_sys_rst: assert property (p_tap_ignores_sys_rst)
    else $error("device reset alone reset the test port");

  property p_pud_test;
    @(posedge mclk) disable iff (sys_rst) pud_test |=> !trst_pullup;
  endproperty
  a_pud_test: assert property (p_pud_test)
    else $error("test reset pull-up stayed on with disable bit set");

  property p_sel_a_reset;
    @(posedge mclk) sys_rst |=> (sel_a == TRPPC_FN_DECODER) ##1 !phase_a_pad_oe;
  endproperty
  a_sel_a_reset: assert property (p_sel_a_reset)
    else $error("phase A pin not on decoder after reset");

  property p_sel_b_reset;
    @(posedge mclk) sys_rst |=> (sel_b == TRPPC_FN_DECODER) ##1 !phase_b_pad_oe;
  endproperty
  a_sel_b_reset: assert property (p_sel_b_reset)
    else $error("phase B pin not on decoder after reset");

  property p_pur_a;
    @(posedge mclk) disable iff (sys_rst) !pur_a |=> !phase_a_pullup;
  endproperty
  a_pur_a: assert property (p_pur_a)
    else $error("phase A pull-up on with bit 4 cleared");

  property p_pur_b;
    @(posedge mclk) disable iff (sys_rst) !pur_b |=> !phase_b_pullup;
  endproperty
  a_pur_b: assert property (p_pur_b)
    else $error("phase B pull-up on with bit 5 cleared");

  property p_gpio_dir;
    @(posedge mclk) disable iff (sys_rst)
      (sel_a == TRPPC_FN_GPIO && sel_b == TRPPC_FN_GPIO)
      |=> (phase_a_pad_oe == $past(dir_a)) && (phase_b_pad_oe == $past(dir_b));
  endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("port c direction not applied per line");

  property p_pullup_reset;
    @(posedge mclk) sys_rst ##1 sys_rst |=> phase_a_pullup && phase_b_pullup && trst_pullup;
  endproperty
  a_pullup_reset: assert property (p_pullup_reset)
    else $error("pull-ups not enabled by device reset");

  property p_bus_ack;
    @(posedge mclk) disable iff (sys_rst) req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack)
    else $error("wishbone answer not one cycle after request");

  c_gpio_out_a: cover property (@(posedge mclk) sel_a == TRPPC_FN_GPIO && phase_a_pad_oe);
  c_timer_b: cover property (@(posedge mclk) sel_b == TRPPC_FN_TIMER && phase_b_pad_oe);
  c_tap_reset: cover property (@(posedge mclk) tap_ctrl_rst && !sys_rst);
  c_pud_set: cover property (@(posedge mclk) pud_test && !trst_pullup);
endmodule // trppc_pin_ctrl

// >>> logic/trppc_pkg.sv
// Purpose: shared constants for the test reset and phase pin control block
// Assumes: 32-bit classic wishbone, byte addresses, one register per word
// Notes: only the low byte of each register is used, upper bits read zero
package trppc_pkg;
  localparam int unsigned TRPPC_AW = 8;
  localparam int unsigned TRPPC_DW = 32;

  localparam logic [7:0] TRPPC_OFS_PORTC_PUR = 8'h00;
  localparam logic [7:0] TRPPC_OFS_SYS_PUD = 8'h04;
  localparam logic [7:0] TRPPC_OFS_FUNC_SEL = 8'h08;
  localparam logic [7:0] TRPPC_OFS_PORTC_DIR = 8'h0c;
  localparam logic [7:0] TRPPC_OFS_PORTC_DATA = 8'h10;
  localparam logic [7:0] TRPPC_OFS_STATUS = 8'h14;

  // port c line positions, shared by pull-up, direction, data and status
  localparam int unsigned TRPPC_LINE_A_BIT = 4;
  localparam int unsigned TRPPC_LINE_B_BIT = 5;
  localparam int unsigned TRPPC_PUD_TEST_BIT = 0;
  localparam int unsigned TRPPC_SEL_A_LSB = 0;
  localparam int unsigned TRPPC_SEL_B_LSB = 2;
  localparam int unsigned TRPPC_ST_TRST_N_BIT = 0;
  localparam int unsigned TRPPC_ST_TAP_RST_BIT = 1;

  typedef enum logic [1:0] {
    TRPPC_FN_DECODER,
    TRPPC_FN_TIMER,
    TRPPC_FN_GPIO,
    TRPPC_FN_SPARE
  } trppc_fn_t;

  localparam logic TRPPC_PUR_RST = 1'b1;
  localparam logic TRPPC_PUD_RST = 1'b0;
  localparam trppc_fn_t TRPPC_SEL_RST = TRPPC_FN_DECODER;
  localparam logic TRPPC_DIR_RST = 1'b0;
  localparam logic TRPPC_DOUT_RST = 1'b0;
  localparam int unsigned TRPPC_ACK_CYCLES = 1;
endpackage

// >>> logic/trppc_phase_pin.sv
// Purpose: function mux for one shared phase pin
// Assumes: pad input already synchronous to mclk
// Notes: every output is registered, so pin effects trail settings by one cycle
`timescale 1ns/1ps
module trppc_phase_pin
  import trppc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire trppc_fn_t fn,
  input wire logic pullup_en,
  input wire logic gpio_dir,
  input wire logic gpio_dout,
  input wire logic timer_out,
  input wire logic timer_oe,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pullup,
  output logic decoder_in,
  output logic timer_in,
  output logic gpio_din
);
  logic next_pad_out;
  logic next_pad_oe;
  logic next_pad_pullup;
  logic next_decoder_in;
  logic next_timer_in;
  logic next_gpio_din;

  always_comb begin
    next_pad_out = 1'b0;
    next_pad_oe = 1'b0;
    next_decoder_in = 1'b0;
    next_timer_in = 1'b0;
    next_gpio_din = 1'b0;
    next_pad_pullup = pullup_en;
    case (fn)
      TRPPC_FN_TIMER: begin
        next_pad_out = timer_out;
        next_pad_oe = timer_oe;
        next_timer_in = pad_in;
      end
      TRPPC_FN_GPIO: begin
        next_pad_out = gpio_dout;
        next_pad_oe = gpio_dir;
        next_gpio_din = pad_in;
      end
      // the spare code falls back to the safe, undriven decoder input
      default: begin
        next_decoder_in = pad_in;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      pad_pullup <= TRPPC_PUR_RST;
      decoder_in <= 1'b0;
      timer_in <= 1'b0;
      gpio_din <= 1'b0;
    end else begin
      pad_out <= next_pad_out;
      pad_oe <= next_pad_oe;
      pad_pullup <= next_pad_pullup;
      decoder_in <= next_decoder_in;
      timer_in <= next_timer_in;
      gpio_din <= next_gpio_din;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_decoder_routed;
    (fn == TRPPC_FN_DECODER) |=> (decoder_in == $past(pad_in)) && !pad_oe;
  endproperty
  a_decoder_routed: assert property (p_decoder_routed)
    else $error("decoder mode did not pass the pad to the decoder");
endmodule // trppc_phase_pin

// >>> logic/trppc_test_reset.sv
// Purpose: test reset pin handling and its pull-up control
// Assumes: test reset pin already synchronous to mclk
// Notes: the test port reset ignores the device reset on purpose
`timescale 1ns/1ps
module trppc_test_reset
  import trppc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic trst_n,
  input wire logic pud_test,
  output logic tap_ctrl_rst,
  output logic trst_pullup
);
  logic next_tap_ctrl_rst;
  logic next_trst_pullup;

  always_comb begin
    next_tap_ctrl_rst = ~trst_n;
    next_trst_pullup = ~pud_test;
  end

  // no device reset here: a debug session must survive it
  always_ff @(posedge mclk) begin
    tap_ctrl_rst <= next_tap_ctrl_rst;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trst_pullup <= ~TRPPC_PUD_RST;
    end else begin
      trst_pullup <= next_trst_pullup;
    end
  end

  property p_tap_follows_pin;
    @(posedge mclk) !trst_n |=> tap_ctrl_rst;
  endproperty
  a_tap_follows_pin: assert property (p_tap_follows_pin)
    else $error("test port reset not raised after low test reset pin");
endmodule // trppc_test_reset

// >>> tb/trppc_probe_model.sv
// Purpose: debug probe and quadrature encoder on the far side of the pins
// Assumes: combinational board wiring, one float toggle per mclk
// Notes: an undriven pad without pull-up wanders so a lost pull-up shows
`timescale 1ns/1ps
module trppc_probe_model (
  input wire logic mclk,
  input wire logic dev_rst,
  input wire logic keep_dbg,
  input wire logic probe_rst,
  input wire logic enc_oe,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic a_oe,
  input wire logic a_out,
  input wire logic a_pu,
  input wire logic b_oe,
  input wire logic b_out,
  input wire logic b_pu,
  output logic trst_n,
  output logic a_in,
  output logic b_in
);
  logic float_bit = 1'b0;
  always_ff @(posedge mclk) begin
    float_bit <= ~float_bit;
  end
  // debug sessions keep the test port alive through a device reset
  assign trst_n = ~((dev_rst & ~keep_dbg) | probe_rst);
  assign a_in = a_oe ? a_out : enc_oe ? enc_a : a_pu ? 1'b1 : float_bit;
  assign b_in = b_oe ? b_out : enc_oe ? enc_b : b_pu ? 1'b1 : float_bit;
endmodule // trppc_probe_model

// >>> tb/test_trppc_pin_ctrl.sv
// Purpose: self-checking bench for the pin control block
// Assumes: one wishbone master, probe model drives the pads
// Notes: pins are checked two edges after a write is acked
`timescale 1ns/1ps
module test_trppc_pin_ctrl;
  import trppc_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [TRPPC_AW-1:0] adr = '0;
  logic [TRPPC_DW-1:0] wdat = '0, rdat;
  logic ack, trst_n, trst_pu, tap_rst;
  logic a_in, a_out, a_oe, a_pu, b_in, b_out, b_oe, b_pu, qa, qb;
  logic t0_out = 1'b0, t0_oe = 1'b0, t1_out = 1'b0, t1_oe = 1'b0;
  logic t0_in, t1_in, pc4, pc5;
  logic keep_dbg = 1'b0, probe_rst = 1'b0;
  logic enc_oe = 1'b0, enc_a = 1'b0, enc_b = 1'b0;
  logic [31:0] rv;
  int n_mismatch = 0;
  int tests_run = 0;

  always #2 mclk = ~mclk;

  trppc_pin_ctrl i_trppc_pin_ctrl (.mclk(mclk), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .trst_n(trst_n), .trst_pullup(trst_pu), .tap_ctrl_rst(tap_rst),
    .phase_a_pad_in(a_in), .phase_a_pad_out(a_out), .phase_a_pad_oe(a_oe),
    .phase_a_pullup(a_pu), .phase_b_pad_in(b_in), .phase_b_pad_out(b_out),
    .phase_b_pad_oe(b_oe), .phase_b_pullup(b_pu), .quad_phase_a_in(qa),
    .quad_phase_b_in(qb), .timer_a_ch0_pin_out(t0_out),
    .timer_a_ch0_pin_oe(t0_oe), .timer_a_ch0_pin_in(t0_in),
    .timer_a_ch1_pin_out(t1_out), .timer_a_ch1_pin_oe(t1_oe),
    .timer_a_ch1_pin_in(t1_in), .portc_line_4(pc4), .portc_line_5(pc5));

  trppc_probe_model i_trppc_probe_model (.mclk(mclk), .dev_rst(sys_rst),
    .keep_dbg(keep_dbg), .probe_rst(probe_rst), .enc_oe(enc_oe),
    .enc_a(enc_a), .enc_b(enc_b), .a_oe(a_oe), .a_out(a_out), .a_pu(a_pu),
    .b_oe(b_oe), .b_out(b_out), .b_pu(b_pu), .trst_n(trst_n),
    .a_in(a_in), .b_in(b_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ack is read in the active region, so this is its value at the edge
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d, rv);
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb_xfer(1'b0, a, 32'h0, rv);
    chk(rv, exp);
  endtask

  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset(input int n);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // release on an edge, then look one nanosecond after the first edge that sees it low
  task automatic end_reset;
    @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic t_reset_values;
    chk({a_pu, b_pu, trst_pu, a_oe, b_oe}, 32'h1c);
    rd_chk(TRPPC_OFS_PORTC_PUR, 32'h30);
    rd_chk(TRPPC_OFS_SYS_PUD, 32'h0);
    rd_chk(TRPPC_OFS_FUNC_SEL, 32'h0);
    rd_chk(TRPPC_OFS_PORTC_DIR, 32'h0);
    rd_chk(8'h18, 32'h0);
  endtask

  task automatic t_decoder;
    enc_oe <= 1'b1;
    enc_a <= 1'b1;
    enc_b <= 1'b0;
    settle();
    chk({qa, qb, t0_in, pc4}, 32'h8);
    @(posedge mclk);
    enc_a <= 1'b0;
    enc_b <= 1'b1;
    settle();
    chk({qa, qb, t1_in, pc5}, 32'h4);
  endtask

  task automatic t_pullups;
    wr(TRPPC_OFS_PORTC_PUR, 32'h20);
    chk({a_pu, b_pu}, 32'h1);
    wr(TRPPC_OFS_PORTC_PUR, 32'h10);
    chk({a_pu, b_pu}, 32'h2);
    wr(TRPPC_OFS_SYS_PUD, 32'h1);
    chk(trst_pu, 32'h0);
    wr(TRPPC_OFS_SYS_PUD, 32'h0);
    chk(trst_pu, 32'h1);
  endtask

  task automatic t_gpio;
    @(posedge mclk);
    enc_oe <= 1'b1;
    enc_b <= 1'b1;
    wr(TRPPC_OFS_FUNC_SEL, 32'ha);
    wr(TRPPC_OFS_PORTC_DATA, 32'h30);
    wr(TRPPC_OFS_PORTC_DIR, 32'h10);
    chk({a_oe, a_out, b_oe, pc5, qb}, 32'h1a);
    wr(TRPPC_OFS_PORTC_DIR, 32'h20);
    chk({a_oe, b_oe, b_out}, 32'h3);
    rd_chk(TRPPC_OFS_PORTC_DATA, 32'h30);
    wr(TRPPC_OFS_PORTC_DIR, 32'h0);
  endtask

  task automatic t_timer;
    @(posedge mclk);
    enc_oe <= 1'b1;
    enc_b <= 1'b1;
    t0_oe <= 1'b1;
    t0_out <= 1'b1;
    wr(TRPPC_OFS_FUNC_SEL, 32'h5);
    chk({a_oe, a_out, b_oe, t1_in, qb, pc5, t0_in}, 32'h69);
    @(posedge mclk);
    t0_oe <= 1'b0;
    t1_oe <= 1'b1;
    t1_out <= 1'b1;
    settle();
    chk({a_oe, b_oe, b_out, t1_in}, 32'h7);
    wr(TRPPC_OFS_FUNC_SEL, 32'hf);
    chk({a_oe, b_oe, qb}, 32'h1);
    @(posedge mclk);
    t1_oe <= 1'b0;
    t1_out <= 1'b0;
  endtask

  task automatic t_test_reset;
    @(posedge mclk);
    probe_rst <= 1'b1;
    settle();
    chk(tap_rst, 32'h1);
    rd_chk(TRPPC_OFS_STATUS, 32'h22);
    @(posedge mclk);
    probe_rst <= 1'b0;
    settle();
    chk(tap_rst, 32'h0);
    @(posedge mclk);
    keep_dbg <= 1'b1;
    do_reset(4);
    chk(tap_rst, 32'h0);
    end_reset();
    rd_chk(TRPPC_OFS_FUNC_SEL, 32'h0);
    keep_dbg <= 1'b0;
    do_reset(4);
    chk({tap_rst, a_pu, b_pu}, 32'h7);
    end_reset();
    settle();
    chk(tap_rst, 32'h0);
  endtask

  initial begin
    repeat (15) @(posedge mclk);
    end_reset();
    t_reset_values();
    t_decoder();
    t_pullups();
    t_gpio();
    t_timer();
    t_test_reset();
    final_report();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    final_report();
  end
endmodule // test_trppc_pin_ctrl
